//--- inc/lcfpg_phase_if.sv
// Interface between pattern logic and the half-cycle phase timer
`timescale 1ns/1ps
`default_nettype none
interface lcfpg_phase_if;
    import lcfpg_pkg::*;
    logic            zc;
    logic [7:0]      num;
    logic [8:0]      den;
    logic            fire;
    logic [HP_W-1:0] half_period;
    modport ctrl  (output zc, num, den, input fire, half_period);
    modport timer (input zc, num, den, output fire, half_period);
endinterface
`default_nettype wire

//--- inc/lcfpg_pkg.sv
// Package: constants and types of the line-cycle firing pattern generator
package lcfpg_pkg;
    // Reference clock rate
    localparam int unsigned CLK_HZ = 10_000_000;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DEMAND   = 8'h04;
    localparam logic [7:0] ADDR_MIN_CYC  = 8'h08;
    localparam logic [7:0] ADDR_RAMP_HC  = 8'h0C;
    localparam logic [7:0] ADDR_DLY_DEG  = 8'h10;
    localparam logic [7:0] ADDR_DLY_HC   = 8'h14;
    localparam logic [7:0] ADDR_CYC_TIME = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_HALF_PER = 8'h20;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_FOLLOW   = 3;
    localparam int CTRL_LIM_EN   = 4;
    localparam int CTRL_ENABLE   = 5;
    // Reset values
    localparam logic [2:0]  RST_MODE     = 3'h0;
    localparam logic [6:0]  RST_DEMAND   = 7'h00;
    localparam logic [7:0]  RST_MIN_CYC  = 8'h01;
    localparam logic [7:0]  RST_RAMP_HC  = 8'h00;
    localparam logic [7:0]  RST_DLY_DEG  = 8'h50;
    localparam logic [7:0]  RST_DLY_HC   = 8'h01;
    localparam logic [15:0] RST_CYC_TIME = 16'h0258;
    // Demand and angle scales
    localparam logic [6:0]  FULL_PCT      = 7'h64;
    localparam logic [8:0]  HALF_TURN_DEG = 9'h0B4;
    // Widths of the half-period timer and the spreading accumulator
    localparam int HP_W  = 20;
    localparam int ACC_W = 18;
    // Firing modes
    typedef enum logic [2:0] {
        MODE_TPROP  = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_BURST  = 3'h2,
        MODE_RAMP   = 3'h3,
        MODE_DELAY  = 3'h4
    } lcfpg_mode_type;
    // Load states, Gray coded along off, fire, on
    typedef enum logic [1:0] {
        ST_OFF  = 2'h0,
        ST_FIRE = 2'h1,
        ST_ON   = 2'h3
    } lcfpg_state_type;
endpackage

//--- rtl/lcfpg_phase_timer.sv
// Half-cycle timer: measures the half period and fires at a set fraction
`timescale 1ns/1ps
`default_nettype none
module lcfpg_phase_timer
    import lcfpg_pkg::*;
(
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    arst_n,
    // Pattern side
    lcfpg_phase_if.timer ph
);
    localparam int PW = HP_W + 9;

    typedef struct packed {
        logic [HP_W-1:0] cnt;
        logic [HP_W-1:0] per;
        logic            fire;
    } lcfpg_tmr_type;

    lcfpg_tmr_type q;
    lcfpg_tmr_type d;
    logic [PW-1:0] lhs;
    logic [PW-1:0] rhs;

    //////////////////////////////////////////////////////////////////////////
    // Fire once elapsed/period reaches num/den; uses last half period
    always_comb begin
        d   = q;
        lhs = PW'(q.cnt) * PW'(ph.den);
        rhs = PW'(q.per) * PW'(ph.num);
        if (ph.zc) begin
            d.cnt  = '0;
            d.per  = q.cnt;
            d.fire = 1'b0;
        end else begin
            // Saturate so a stopped line never wraps the count
            if (q.cnt != '1) begin
                d.cnt = q.cnt + 1'b1;
            end
            if (lhs >= rhs) begin
                d.fire = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ph.fire        = q.fire;
    assign ph.half_period = q.per;

    //////////////////////////////////////////////////////////////////////////
    // Once fired, the gate holds to the end of the half cycle
    property p_fire_hold;
        @(posedge clk) disable iff (!arst_n)
        q.fire && !ph.zc |=> q.fire;
    endproperty
    a_fire_hold: assert property (p_fire_hold)
        else $error("phase fire dropped inside half cycle");

    // Each zero crossing re-arms the delay
    property p_fire_rearm;
        @(posedge clk) disable iff (!arst_n)
        ph.zc |=> !q.fire;
    endproperty
    a_fire_rearm: assert property (p_fire_rearm)
        else $error("phase fire not cleared at zero cross");
endmodule
`default_nettype wire

//--- rtl/lcfpg_top.sv
// Line-cycle firing pattern generator with APB register slave
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module lcfpg_top
    import lcfpg_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Line and control pins
    input  wire logic        LINE_PHASE,
    input  wire logic        CTRL_IN,
    input  wire logic        OVER_CURRENT,
    // Gate drive
    output logic             GATE_DRIVE,
    output logic             LOAD_ON
);
    //////////////////////////////////////////////////////////////////////////
    // All state of the block
    typedef struct packed {
        // Software registers
        logic [2:0]      mode;
        logic            follow;
        logic            lim_en;
        logic            en;
        logic [6:0]      demand;
        logic [7:0]      min_cyc;
        logic [7:0]      ramp_hc;
        logic [7:0]      dly_deg;
        logic [7:0]      dly_hc;
        logic [15:0]     cyc_time;
        logic [31:0]     rdata;
        logic            slverr;
        // Pin synchronisers; ph_s[2] is the edge-detect stage
        logic [2:0]      ph_s;
        logic [1:0]      in_s;
        logic [1:0]      oc_s;
        // Settings held for the running line cycle
        lcfpg_mode_type  c_mode;
        logic            c_follow;
        logic [6:0]      c_dem;
        logic [7:0]      c_min;
        logic [7:0]      c_ramp;
        logic [7:0]      c_dly;
        logic [7:0]      c_dhc;
        logic [15:0]     c_ct;
        // Pattern state
        lcfpg_state_type st;
        logic            want;
        logic            load_on;
        logic            lim;
        logic [7:0]      run;
        logic [15:0]     pos;
        logic [ACC_W-1:0] acc;
        logic [7:0]      hc_left;
    } lcfpg_core_type;

    lcfpg_core_type q;
    lcfpg_core_type d;

    lcfpg_phase_if ph ();

    logic                    zc_edge;
    logic                    line_edge;
    logic                    lim_now;
    logic                    gate_w;
    logic                    cont;
    logic                    want_n;
    logic                    tp_on;
    logic [7:0]              n_run;
    logic signed [ACC_W-1:0] dn;
    logic signed [ACC_W-1:0] fn;
    logic signed [ACC_W-1:0] sum;

    //////////////////////////////////////////////////////////////////////////
    // Run length of one decision: one cycle, or the minimum (never zero)
    function automatic logic [7:0] run_len(input lcfpg_mode_type m,
                                           input logic [7:0] mn);
        if (m == MODE_TPROP || m == MODE_SINGLE || mn == 8'h00) begin
            return 8'h01;
        end
        return mn;
    endfunction

    // Follow role only in the pure zero-cross modes, never with phase firing
    function automatic logic follow_ok(input lcfpg_mode_type m);
        return (m == MODE_TPROP || m == MODE_SINGLE || m == MODE_BURST);
    endfunction

    // Clamp a written demand to full output
    function automatic logic [6:0] clamp_pct(input logic [31:0] v);
        if (v > 32'(FULL_PCT)) begin
            return FULL_PCT;
        end
        return v[6:0];
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Zero crossings: any edge of the line phase; rising edge ends a cycle
    assign zc_edge   = q.ph_s[1] ^ q.ph_s[2];
    assign line_edge = q.ph_s[1] & ~q.ph_s[2];
    assign lim_now   = q.lim_en & q.oc_s[1];

    //////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        d      = q;
        cont   = 1'b0;
        want_n = q.want;
        tp_on  = 1'b0;
        n_run  = 8'h01;
        dn     = '0;
        fn     = '0;
        sum    = '0;

        // Two-stage synchronisers, then one more stage for edge detect
        d.ph_s = {q.ph_s[1:0], LINE_PHASE};
        d.in_s = {q.in_s[0], CTRL_IN};
        d.oc_s = {q.oc_s[0], OVER_CURRENT};

        // APB read data and error, captured in the setup phase
        if (PSEL && !PENABLE) begin
            d.slverr = 1'b0;
            case (PADDR)
                ADDR_CTRL:     d.rdata = {26'h0, q.en, q.lim_en, q.follow,
                                          q.mode};
                ADDR_DEMAND:   d.rdata = {25'h0, q.demand};
                ADDR_MIN_CYC:  d.rdata = {24'h0, q.min_cyc};
                ADDR_RAMP_HC:  d.rdata = {24'h0, q.ramp_hc};
                ADDR_DLY_DEG:  d.rdata = {24'h0, q.dly_deg};
                ADDR_DLY_HC:   d.rdata = {24'h0, q.dly_hc};
                ADDR_CYC_TIME: d.rdata = {16'h0, q.cyc_time};
                ADDR_STATUS:   d.rdata = {26'h0, q.want, q.lim, q.in_s[1],
                                          q.st == ST_FIRE, gate_w,
                                          q.load_on};
                ADDR_HALF_PER: d.rdata = 32'(ph.half_period);
                default: begin
                    d.rdata  = 32'h0;
                    d.slverr = 1'b1;
                end
            endcase
        end

        // APB writes take effect in the access phase
        if (PSEL && PENABLE && PWRITE) begin
            case (PADDR)
                ADDR_CTRL: begin
                    d.mode   = PWDATA[CTRL_MODE_MSB:CTRL_MODE_LSB];
                    d.follow = PWDATA[CTRL_FOLLOW];
                    d.lim_en = PWDATA[CTRL_LIM_EN];
                    d.en     = PWDATA[CTRL_ENABLE];
                end
                ADDR_DEMAND:   d.demand   = clamp_pct(PWDATA);
                ADDR_MIN_CYC:  d.min_cyc  = PWDATA[7:0];
                ADDR_RAMP_HC:  d.ramp_hc  = PWDATA[7:0];
                ADDR_DLY_DEG:  d.dly_deg  = PWDATA[7:0];
                ADDR_DLY_HC:   d.dly_hc   = PWDATA[7:0];
                ADDR_CYC_TIME: d.cyc_time = PWDATA[15:0];
                default: ;
            endcase
        end

        // Settings change only at a line-cycle boundary
        if (line_edge) begin
            d.c_mode   = lcfpg_mode_type'(q.mode);
            d.c_follow = q.follow;
            d.c_dem    = q.demand;
            d.c_min    = q.min_cyc;
            d.c_ramp   = q.ramp_hc;
            d.c_dly    = q.dly_deg;
            d.c_dhc    = q.dly_hc;
            d.c_ct     = q.cyc_time;
        end
        cont = d.c_follow && follow_ok(d.c_mode);

        // Phase-fired half cycles count down at every zero crossing
        if (zc_edge && q.st == ST_FIRE) begin
            if (q.hc_left <= 8'h01) begin
                d.st      = ST_ON;
                d.hc_left = 8'h00;
            end else begin
                d.hc_left = q.hc_left - 8'h01;
            end
        end

        if (zc_edge) begin
            d.lim = lim_now;
        end

        if (zc_edge && (!q.en || cont)) begin
            // Contactor: no demand, no spreading, just the input
            want_n    = q.en & q.in_s[1];
            d.want    = want_n;
            d.load_on = want_n & ~lim_now;
            d.st      = d.load_on ? ST_ON : ST_OFF;
            d.run     = 8'h00;
            d.hc_left = 8'h00;
        end else if (line_edge) begin
            // Time-proportioned window position
            if (q.pos + 16'h0001 >= d.c_ct) begin
                d.pos = 16'h0000;
            end else begin
                d.pos = q.pos + 16'h0001;
            end
            tp_on = (32'(q.pos) * 32'(FULL_PCT)) <
                    (32'(d.c_dem) * 32'(d.c_ct));
            if (q.run > 8'h01) begin
                // Inside a run: hold the decision
                d.run  = q.run - 8'h01;
                want_n = q.want;
            end else begin
                n_run = run_len(d.c_mode, d.c_min);
                dn    = ACC_W'(d.c_dem) * ACC_W'(n_run);
                fn    = ACC_W'(FULL_PCT) * ACC_W'(n_run);
                sum   = $signed(q.acc) + dn;
                case (d.c_mode)
                    MODE_TPROP: begin
                        want_n = tp_on;
                    end
                    MODE_SINGLE, MODE_BURST, MODE_RAMP, MODE_DELAY: begin
                        // Error feedback spreads runs by demand
                        if (d.c_dem >= FULL_PCT) begin
                            want_n = 1'b1;
                        end else if (d.c_dem == 7'h00) begin
                            want_n = 1'b0;
                        end else begin
                            want_n = sum >= (fn >>> 1);
                        end
                        d.acc = ACC_W'(sum - (want_n ? fn : '0));
                    end
                    default: begin
                        want_n = 1'b0;
                    end
                endcase
                d.run = n_run;
            end
            d.want    = want_n;
            d.load_on = want_n & ~lim_now;
            if (!d.load_on) begin
                d.st      = ST_OFF;
                d.hc_left = 8'h00;
            end else if (!q.load_on) begin
                // New burst: optional phase-fired start
                if (d.c_mode == MODE_RAMP && d.c_ramp != 8'h00) begin
                    d.st      = ST_FIRE;
                    d.hc_left = d.c_ramp;
                end else if (d.c_mode == MODE_DELAY && d.c_dhc != 8'h00) begin
                    d.st      = ST_FIRE;
                    d.hc_left = d.c_dhc;
                end else begin
                    d.st = ST_ON;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register; async reset loads constants only
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q          <= '0;
            q.mode     <= RST_MODE;
            q.demand   <= RST_DEMAND;
            q.min_cyc  <= RST_MIN_CYC;
            q.ramp_hc  <= RST_RAMP_HC;
            q.dly_deg  <= RST_DLY_DEG;
            q.dly_hc   <= RST_DLY_HC;
            q.cyc_time <= RST_CYC_TIME;
            q.c_min    <= RST_MIN_CYC;
            q.c_ct     <= RST_CYC_TIME;
            q.st       <= ST_OFF;
        end else begin
            q <= d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Phase timer: ramp angle falls 180*left/(n+1); delay is a fixed angle
    assign ph.zc  = zc_edge;
    assign ph.num = (q.c_mode == MODE_RAMP) ? q.hc_left : q.c_dly;
    assign ph.den = (q.c_mode == MODE_RAMP) ? ({1'b0, q.c_ramp} + 9'h001)
                                            : HALF_TURN_DEG;

    lcfpg_phase_timer u_timer (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .ph     (ph)
    );

    // Gate waits for the timer while a start half cycle is phase fired
    assign gate_w = q.load_on & ((q.st != ST_FIRE) | ph.fire);

    // Outputs; zero-wait APB
    assign GATE_DRIVE = gate_w;
    assign LOAD_ON    = q.load_on;
    assign PRDATA     = q.rdata;
    assign PREADY     = 1'b1;
    assign PSLVERR    = q.slverr & PSEL & PENABLE;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);

    property p_follow_on;
        zc_edge && !line_edge && q.en && q.in_s[1] && !lim_now &&
        q.c_follow && follow_ok(q.c_mode) |=> q.load_on;
    endproperty
    a_follow_on: assert property (p_follow_on)
        else $error("contactor did not follow high input");

    property p_follow_off;
        zc_edge && !line_edge && !q.in_s[1] &&
        q.c_follow && follow_ok(q.c_mode) |=> !q.load_on;
    endproperty
    a_follow_off: assert property (p_follow_off)
        else $error("contactor did not follow low input");

    property p_zc_only;
        $changed(q.load_on) |-> $past(zc_edge);
    endproperty
    a_zc_only: assert property (p_zc_only)
        else $error("load changed away from a zero crossing");

    property p_limit;
        zc_edge && lim_now |=> !q.load_on;
    endproperty
    a_limit: assert property (p_limit)
        else $error("current limit did not drop the cycle");

    property p_run_hold;
        line_edge && q.run > 8'h01 && q.en && !cont |=> $stable(q.want);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("run broken before minimum length");

    property p_full;
        line_edge && q.en && !cont && q.run <= 8'h01 &&
        q.demand == FULL_PCT && q.mode != 3'(MODE_TPROP) |=> q.want;
    endproperty
    a_full: assert property (p_full)
        else $error("full demand not continuous");

    property p_zero;
        line_edge && !cont && q.run <= 8'h01 && q.demand == 7'h00
        |=> !q.want ##1 !q.load_on;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero demand produced an on run");

    sequence s_ramp_begin;
        line_edge && !q.load_on && q.mode == 3'(MODE_RAMP) &&
        q.ramp_hc != 8'h00 ##1 q.load_on;
    endsequence
    property p_ramp;
        s_ramp_begin |-> q.st == ST_FIRE && q.hc_left == q.c_ramp;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("burst did not start with ramp");

    property p_delay_gate;
        q.st == ST_FIRE && !ph.fire |-> !GATE_DRIVE;
    endproperty
    a_delay_gate: assert property (p_delay_gate)
        else $error("gate before firing angle");

    property p_cfg_hold;
        !line_edge |=> $stable(q.c_dem) && $stable(q.c_mode);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed inside a line cycle");
endmodule
`default_nettype wire

//--- test/lcfpg_line_model.sv
// Line model: square wave line polarity with a fixed half period
`timescale 1ns/1ps
`default_nettype none
module lcfpg_line_model #(
    parameter int HALF = 100
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Line polarity, each edge is a zero crossing
    output logic      line_phase
);
    int cnt;
    // Line turns freely; the load never stops the mains
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt        <= 0;
            line_phase <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt        <= 0;
            line_phase <= ~line_phase;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

//--- test/line_cycle_firing_pattern_gen_tb_top.sv
// Testbench of the line-cycle firing pattern generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); end end
module line_cycle_firing_pattern_gen_tb_top
    import lcfpg_pkg::*;
;
    logic        clk, arst_n, psel, penable, pwrite, ctrl_in, over_cur;
    logic        pready, pslverr, line_phase, gate, load_on, rerr, prev;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, seed;
    int          errors, check_count, cycles, on, mr, n;
    int          dem[4] = '{25, 50, 75, 100};
    // Clock; timeout sized well above the expected run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            finish_test();
        end
    end
    lcfpg_line_model #(.HALF(100)) i_line (.clk(clk), .arst_n(arst_n),
        .line_phase(line_phase));
    lcfpg_top i_dut (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINE_PHASE(line_phase), .CTRL_IN(ctrl_in), .OVER_CURRENT(over_cur),
        .GATE_DRIVE(gate), .LOAD_ON(load_on));
    //////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] ctl(lcfpg_mode_type m, logic f, logic l);
        return {26'h0, 1'b1, l, f, m};
    endfunction
    task automatic finish_test();
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // APB master: request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // Samples late in the positive half, after a delayed start has fired,
    // so the gate must agree with the load; tracks the shortest inner run
    task automatic count_on(input int c);
        int run;
        logic chg;
        on = 0;
        run = 0;
        mr = 99;
        chg = 1'b0;
        prev = load_on;
        for (int i = 0; i < c; i++) begin
            @(posedge line_phase);
            repeat (75) @(posedge clk);
            `CHK(gate, load_on)
            on += (load_on === 1'b1);
            if (load_on !== prev) begin
                if (chg) mr = (run < mr) ? run : mr;
                chg = 1'b1;
                run = 0;
            end
            run++;
            prev = load_on;
        end
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ctrl_in, over_cur} = '0;
        {arst_n, errors, check_count, cycles} = '0;
        seed = 32'h397D;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_MIN_CYC, 32'h1);
        rd_chk(ADDR_DLY_DEG, 32'h50);
        rd_chk(ADDR_DLY_HC, 32'h1);
        rd_chk(ADDR_CYC_TIME, 32'h258);
        apb(1'b1, 8'h02, rnd(seed));
        `CHK(rerr, 1'b1)
        rd_chk(8'h24, 32'h0);
        `CHK(rerr, 1'b1)
        rd_chk(ADDR_CTRL, 32'h0);
        // Single-cycle ratios after a settling window
        apb(1'b1, ADDR_CTRL, ctl(MODE_SINGLE, 1'b0, 1'b0));
        foreach (dem[i]) begin
            apb(1'b1, ADDR_DEMAND, 32'(dem[i]));
            count_on(4);
            count_on(16);
            `CHK(on, dem[i] * 16 / 100)
        end
        // Burst with four-cycle minimum runs
        apb(1'b1, ADDR_CTRL, ctl(MODE_BURST, 1'b0, 1'b0));
        apb(1'b1, ADDR_MIN_CYC, 32'h4);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_DEMAND, 32'(dem[i]));
            count_on(16);
            count_on(16);
            `CHK(on, dem[i] * 16 / 100)
            `CHK(mr >= 4, 1'b1)
        end
        // Contactor: follow the input, only at zero crossings
        apb(1'b1, ADDR_DEMAND, 32'h64);
        apb(1'b1, ADDR_CTRL, ctl(MODE_TPROP, 1'b1, 1'b1));
        for (int i = 0; i < 8; i++) begin
            seed = rnd(seed);
            @(line_phase);
            repeat (50) @(posedge clk);
            prev = load_on;
            ctrl_in <= seed[0];
            repeat (10) @(posedge clk);
            `CHK(load_on, prev)
            @(line_phase);
            repeat (10) @(posedge clk);
            `CHK(load_on, seed[0])
        end
        ctrl_in <= 1'b1;
        over_cur <= 1'b1;
        repeat (2) @(line_phase);
        repeat (10) @(posedge clk);
        `CHK(load_on, 1'b0)
        over_cur <= 1'b0;
        // Delayed trigger at ninety degrees, then two-cycle runs
        apb(1'b1, ADDR_DEMAND, 32'h0);
        apb(1'b1, ADDR_CTRL, ctl(MODE_DELAY, 1'b0, 1'b0));
        apb(1'b1, ADDR_DLY_DEG, 32'h5A);
        apb(1'b1, ADDR_MIN_CYC, 32'h2);
        count_on(3);
        apb(1'b1, ADDR_DEMAND, 32'h64);
        for (n = 0; n < 3000 && load_on !== 1'b1; n++) @(posedge clk);
        repeat (20) @(posedge clk);
        `CHK(gate, 1'b0)
        repeat (60) @(posedge clk);
        `CHK(gate, 1'b1)
        count_on(4);
        `CHK(on, 4)
        apb(1'b1, ADDR_DEMAND, 32'h32);
        count_on(8);
        count_on(8);
        `CHK(on, 4)
        `CHK(mr >= 2, 1'b1)
        finish_test();
    end
endmodule
`default_nettype wire
